/* core/crs_register_set.sv */
// core register set: accumulator, index, stack pointer, program counter, vectors
// ----------------------------------------------------------------
// Notes on behaviour
// - An 8-bit accumulator feeds operands to and takes results from the ALU.
// - The 16-bit index register is an upper byte concatenated above a lower byte.
// - The index register spans the full 64-Kbyte address space in indexed modes.
// - Indexed operand addresses come from the current index register contents.
// - The index register also holds temporary data until overwritten.
// - A 16-bit stack pointer always names the next free stack byte.
// - Any reset presets the stack pointer to 00ff.
// - The stack-low-byte reinit instruction sets the low byte to ff, keeping the high byte.
// - The stack pointer decrements per pushed byte and increments per pulled byte.
// - Stack offset modes add an 8- or 16-bit offset to the stack pointer.
// - A 16-bit program counter names the next byte and advances by one per fetch.
// - Jumps, branches and interrupts load the program counter with a target.
// - On leaving reset the program counter loads the vector at fffe:ffff.
// - The vector table holds high:low pairs, priority rising with address from ffd8.
// - The software trap vector sits at fffc:fffd, just below reset.
// - The first external interrupt vector is at fffa:fffb, clock synth at fff8:fff9.
// - The registers sit in no memory-map address; only instructions and the read-only debug bus reach them.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module crs_register_set
    import crs_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                arst_n,
    input  wire logic                clkEn,
    // sequencer command port
    input  wire crs_cmd_s            cmd,
    input  wire logic [NUM_VEC-1:0]  vecReq,
    output logic [ADDR_W-1:0]        opAddr,
    output logic [ADDR_W-1:0]        vecAddr,
    output logic                     vecFetch,
    output logic                     running,
    output logic [DATA_W-1:0]        accOut,
    output logic [ADDR_W-1:0]        idxOut,
    output logic [ADDR_W-1:0]        spOut,
    output logic [ADDR_W-1:0]        pcOut,
    // vector byte read back from memory
    input  wire logic [7:0]          vecData,
    // debug wishbone slave, read-only view
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o
);
    crs_state_s q_r;
    crs_state_s q_nxt;
    logic [ADDR_W-1:0] offExt;
    logic [4:0]        winIdx;
    logic              anyReq;

    // highest-priority pending source: larger index, higher address
    always_comb begin
        winIdx = VEC_IDX_W;
        anyReq = 1'b0;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (vecReq[i]) begin
                winIdx = i[4:0];
                anyReq = 1'b1;
            end
        end
    end

    always_comb begin
        q_nxt = q_r;
        offExt = cmd.offset;
        if (cmd.amode == AM_SP8) begin
            offExt = {8'h00, cmd.offset[7:0]};
        end
        q_nxt.wbAck = 1'b0;
        case (q_r.state)
            ST_RESET: begin
                q_nxt.vecAddr = VEC_RESET;
                q_nxt.state = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                q_nxt.vecHi = vecData;
                q_nxt.vecAddr = q_r.vecAddr + ONE16;
                q_nxt.state = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                q_nxt.pc = {q_r.vecHi, vecData};
                q_nxt.state = ST_RUN;
            end
            ST_RUN: begin
                if (cmd.fetch) begin
                    q_nxt.pc = q_r.pc + ONE16;
                end
                case (cmd.op)
                    OP_ACC_LD:  q_nxt.acc = cmd.data[DATA_W-1:0];
                    OP_IDX_LD:  q_nxt.idx = cmd.data;
                    OP_IDXH_LD: q_nxt.idx = {cmd.data[7:0], q_r.idx[7:0]};
                    OP_IDXL_LD: q_nxt.idx = {q_r.idx[15:8], cmd.data[7:0]};
                    OP_SP_LD:   q_nxt.sp = cmd.data;
                    OP_SP_RST:  q_nxt.sp = {q_r.sp[15:8], SP_LOW_ONES};
                    OP_PUSH:    q_nxt.sp = q_r.sp - ONE16;
                    OP_PULL:    q_nxt.sp = q_r.sp + ONE16;
                    OP_PC_LD:   q_nxt.pc = cmd.data;
                    OP_VEC_HI: begin
                        // trap, external, clock-synth all land on fixed pairs
                        q_nxt.vecAddr = VEC_BASE +
                            ADDR_W'({11'h000, winIdx} * VEC_PAIR_STEP);
                        q_nxt.state = ST_VEC_HI;
                    end
                    default: ;
                endcase
            end
            default: q_nxt.state = ST_RESET;
        endcase
        case (cmd.amode)
            AM_INDEX: q_nxt.opAddr = q_r.idx;
            AM_SP8,
            AM_SP16:  q_nxt.opAddr = q_r.sp + offExt;
            default:  q_nxt.opAddr = q_r.pc;
        endcase
        // debug bus: reads only, writes ignored so the core map stays empty
        if (wb_cyc_i && wb_stb_i && !q_r.wbAck) begin
            q_nxt.wbAck = 1'b1;
            case (wb_adr_i)
                OFS_ACC: q_nxt.wbDat = {24'h000000, q_r.acc};
                OFS_IDX: q_nxt.wbDat = {16'h0000, q_r.idx};
                OFS_STK: q_nxt.wbDat = {16'h0000, q_r.sp};
                OFS_PC:  q_nxt.wbDat = {16'h0000, q_r.pc};
                default: q_nxt.wbDat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '{state: ST_RESET, sp: SP_RESET, default: '0};
        end else if (clkEn) begin
            q_r <= q_nxt;
        end
    end

    assign opAddr   = q_r.opAddr;
    assign vecAddr  = q_r.vecAddr;
    assign vecFetch = (q_r.state == ST_VEC_HI) || (q_r.state == ST_VEC_LO);
    assign running  = (q_r.state == ST_RUN);
    assign accOut   = q_r.acc;
    assign idxOut   = q_r.idx;
    assign spOut    = q_r.sp;
    assign pcOut    = q_r.pc;
    assign wb_dat_o = q_r.wbDat;
    assign wb_ack_o = q_r.wbAck;

    logic unusedIn;
    assign unusedIn = ^{wb_we_i, wb_sel_i, wb_dat_i, anyReq};
endmodule
`default_nettype wire

/* core/crs_pkg.sv */
// constants and carrier types for the core register set
package crs_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam logic [ADDR_W-1:0] SP_RESET = 16'h00ff;
    localparam logic [7:0] SP_LOW_ONES = 8'hff;
    localparam logic [ADDR_W-1:0] ONE16 = 16'h0001;
    localparam logic [ADDR_W-1:0] VEC_BASE = 16'hffd8;
    localparam logic [ADDR_W-1:0] VEC_RESET = 16'hfffe;
    localparam logic [ADDR_W-1:0] VEC_SWTRAP = 16'hfffc;
    localparam logic [ADDR_W-1:0] VEC_EXTINT1 = 16'hfffa;
    localparam logic [ADDR_W-1:0] VEC_CLKSYN = 16'hfff8;
    localparam int unsigned NUM_VEC = 20;
    localparam logic [4:0] VEC_IDX_W = 5'h00;
    localparam logic [ADDR_W-1:0] VEC_PAIR_STEP = 16'h0002;

    // wishbone offsets: byte addresses of 32-bit words
    localparam logic [3:0] OFS_ACC = 4'h0;
    localparam logic [3:0] OFS_IDX = 4'h4;
    localparam logic [3:0] OFS_STK = 4'h8;
    localparam logic [3:0] OFS_PC = 4'hc;

    // register-file operation codes from the sequencer
    typedef enum logic [3:0] {
        OP_NONE, OP_ACC_LD, OP_IDX_LD, OP_IDXH_LD, OP_IDXL_LD, OP_SP_LD,
        OP_SP_RST, OP_PUSH, OP_PULL, OP_PC_LD, OP_VEC_HI, OP_VEC_LO
    } crs_op_e;

    typedef enum logic [1:0] { AM_INDEX, AM_SP8, AM_SP16, AM_PC } crs_amode_e;

    typedef enum { ST_RESET, ST_VEC_HI, ST_VEC_LO, ST_RUN } crs_state_e;

    typedef struct packed {
        crs_op_e           op;
        logic [ADDR_W-1:0] data;
        logic              fetch;
        crs_amode_e        amode;
        logic [ADDR_W-1:0] offset;
    } crs_cmd_s;

    typedef struct packed {
        crs_state_e        state;
        logic [DATA_W-1:0] acc;
        logic [ADDR_W-1:0] idx;
        logic [ADDR_W-1:0] sp;
        logic [ADDR_W-1:0] pc;
        logic [7:0]        vecHi;
        logic [ADDR_W-1:0] vecAddr;
        logic [ADDR_W-1:0] opAddr;
        logic              wbAck;
        logic [31:0]       wbDat;
    } crs_state_s;
endpackage

/* tb/crs_register_set_asserts.sv */
// concurrent checks on the core register set ports
`timescale 1ns/1ps
`default_nettype none
module crs_register_set_asserts
    import crs_pkg::*;
(
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire logic              clkEn,
    input wire crs_cmd_s          cmd,
    input wire logic [7:0]        vecData,
    input wire logic [ADDR_W-1:0] opAddr,
    input wire logic [ADDR_W-1:0] vecAddr,
    input wire logic              running,
    input wire logic [DATA_W-1:0] accOut,
    input wire logic [ADDR_W-1:0] idxOut,
    input wire logic [ADDR_W-1:0] spOut,
    input wire logic [ADDR_W-1:0] pcOut
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // commands only count while running and enabled
    wire en = running & clkEn;
    stack_reset_a: assert property ($rose(arst_n) |-> spOut == SP_RESET)
        else $error("stack pointer not preset");
    stack_push_a: assert property (en && cmd.op == OP_PUSH |=> spOut == $past(spOut) - 16'h1)
        else $error("push step wrong");
    stack_pull_a: assert property (en && cmd.op == OP_PULL |=> spOut == $past(spOut) + 16'h1)
        else $error("pull step wrong");
    stack_fill_a: assert property (en && cmd.op == OP_SP_RST |=>
        spOut == {$past(spOut[15:8]), 8'hff}) else $error("low byte fill wrong");
    count_step_a: assert property (en && cmd.fetch && cmd.op == OP_NONE |=>
        pcOut == $past(pcOut) + 16'h1) else $error("fetch step wrong");
    count_load_a: assert property (en && cmd.op == OP_PC_LD |=> pcOut == $past(cmd.data))
        else $error("target load wrong");
    acc_load_a: assert property (en && cmd.op == OP_ACC_LD |=>
        accOut == $past(cmd.data[7:0])) else $error("accumulator load wrong");
    index_addr_a: assert property (en && cmd.amode == AM_INDEX |=> opAddr == $past(idxOut))
        else $error("indexed address wrong");
    stack_off_a: assert property (en && cmd.amode == AM_SP8 |=>
        opAddr == $past(spOut) + {8'h00, $past(cmd.offset[7:0])}) else $error("offset wrong");
    reset_vec_a: assert property ($rose(arst_n) && clkEn |=> vecAddr == 16'hfffe
        ##1 vecAddr == 16'hffff
        ##1 running && pcOut == {$past(vecData, 2), $past(vecData)}) else $error("boot load wrong");
    cover property (en && cmd.op == OP_SP_RST);
    cover property (en && cmd.op == OP_VEC_HI ##1 !running);
    cover property (en && cmd.amode == AM_SP16);
endmodule
`default_nettype wire

/* tb/tb_crs_register_set.sv */
// self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_crs_register_set
    import crs_pkg::*;
;
    logic               mclk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, vecFetch, running, wb_ack_o;
    crs_cmd_s           cmd = '0;
    logic [NUM_VEC-1:0] vecReq = '0;
    logic [7:0]         vecData;
    logic [ADDR_W-1:0]  opAddr, vecAddr, idxOut, spOut, pcOut;
    logic [DATA_W-1:0]  accOut;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]         wb_adr_i = '0, wb_sel_i = 4'hf;
    logic [31:0]        wb_dat_i = '1, wb_dat_o;
    int                 mismatches = 0, comparisons = 0, cycles = 0;
    always #25 mclk = ~mclk;
    // vector memory: byte is address xor a pattern, so each pair is distinct
    always_comb vecData = vecAddr[7:0] ^ 8'h5a;
    crs_register_set dut (.mclk, .arst_n, .clkEn, .cmd, .vecReq, .opAddr, .vecAddr, .vecFetch,
        .running, .accOut, .idxOut, .spOut, .pcOut, .vecData, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    task automatic end_sim;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] exp);
        int n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        do @(posedge mclk); while (wb_ack_o !== 1'b1 && ++n < 20);
        `CHK({wb_ack_o, we ? exp : wb_dat_o}, {1'b1, exp})
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic op(input crs_op_e o, input logic [15:0] d = 0, input logic f = 0,
                      input crs_amode_e m = AM_INDEX, input logic [15:0] off = 0);
        @(posedge mclk);
        cmd <= '{o, d, f, m, off};
        @(posedge mclk);
        cmd <= '0;
        @(negedge mclk);
    endtask
    task automatic waitRun;
        repeat (20) begin
            @(negedge mclk);
            if (running === 1'b1) break;
        end
    endtask
    task automatic tRegs;
        op(OP_ACC_LD, 16'h005c);
        op(OP_IDX_LD, 16'hbeef);
        `CHK(accOut, 8'h5c)
        op(OP_NONE, 16'h1234, 1'b1);
        `CHK({idxOut, opAddr}, {16'hbeef, 16'hbeef})
        wb(1'b1, OFS_IDX, 32'h0);
        wb(1'b0, OFS_IDX, 32'h0000beef);
        wb(1'b0, 4'h2, 32'h0);
    endtask
    task automatic tStack;
        op(OP_SP_LD, 16'h0100);
        op(OP_PUSH);
        `CHK(spOut, 16'h00ff)
        op(OP_PULL);
        `CHK(spOut, 16'h0100)
        op(OP_SP_RST);
        `CHK(spOut, 16'h01ff)
        op(OP_NONE, 0, 0, AM_SP8, 16'hff80);
        `CHK(opAddr, 16'h027f)
        op(OP_NONE, 0, 0, AM_SP16, 16'hff80);
        `CHK(opAddr, 16'h017f)
        // enable low must freeze every register, so a push is lost
        @(posedge mclk);
        clkEn <= 1'b0;
        op(OP_PUSH);
        `CHK(spOut, 16'h01ff)
        @(posedge mclk);
        clkEn <= 1'b1;
    endtask
    task automatic tCount;
        op(OP_PC_LD, 16'hfffe);
        op(OP_NONE, 0, 1'b1);
        op(OP_NONE, 0, 1'b1);
        `CHK(pcOut, 16'h0000)
        op(OP_PC_LD, 16'h4321, 1'b1);
        `CHK(pcOut, 16'h4321)
    endtask
    task automatic tVec;
        logic [19:0] req [4] = '{20'h70001, 20'h30001, 20'h10000, 20'h00001};
        logic [15:0] va [4] = '{16'hfffc, 16'hfffa, 16'hfff8, 16'hffd8};
        foreach (req[i]) begin
            @(posedge mclk);
            vecReq <= req[i];
            op(OP_VEC_HI);
            `CHK({vecFetch, vecAddr}, {1'b1, va[i]})
            waitRun();
            `CHK(pcOut, {va[i][7:0] ^ 8'h5a, (va[i][7:0] + 8'h01) ^ 8'h5a})
        end
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        waitRun();
        `CHK({pcOut, spOut}, {16'ha4a5, SP_RESET})
        wb(1'b0, OFS_STK, 32'h000000ff);
        tRegs();
        tStack();
        tCount();
        tVec();
        // second reset in mid-run: stack preset and boot vector again
        @(posedge mclk);
        arst_n <= 1'b0;
        @(posedge mclk);
        arst_n <= 1'b1;
        waitRun();
        `CHK({pcOut, spOut}, {16'ha4a5, SP_RESET})
        end_sim();
    end
endmodule
bind crs_register_set crs_register_set_asserts u_chk (.mclk, .arst_n, .clkEn, .cmd, .vecData,
    .opAddr, .vecAddr, .running, .accOut, .idxOut, .spOut, .pcOut);
`default_nettype wire
